// >>> logic/fpec_pkg.sv
// Constants for the flash page erase control block.
// Assumes a 10 MHz APB clock and a byte-wide flash array behind the block.
package fpec_pkg;
   // Array map (byte addresses on the flash side)
   localparam logic [15:0] FPEC_USER_LO     = 16'hE000;
   localparam logic [15:0] FPEC_USER_HI     = 16'hFDFF;
   localparam logic [15:0] FPEC_CTRL_ADDR   = 16'hFE08;
   localparam logic [15:0] FPEC_PROT_ADDR   = 16'hFF7E;
   localparam logic [15:0] FPEC_VECT_LO     = 16'hFFD4;
   localparam logic [15:0] FPEC_VECT_HI     = 16'hFFFF;
   localparam int          FPEC_USER_BYTES  = 7936;
   localparam int          FPEC_VECT_BYTES  = 44;
   localparam int          FPEC_PAGE_BYTES  = 64;
   localparam int          FPEC_ROW_BYTES   = 32;
   // APB byte offsets
   localparam logic [15:0] FPEC_OFS_CTRL    = 16'hFE08;
   localparam logic [15:0] FPEC_OFS_PROT    = 16'hFF7C;
   localparam logic [15:0] FPEC_OFS_STAT    = 16'h0000;
   localparam logic [15:0] FPEC_OFS_PAGE    = 16'h0004;
   localparam logic [15:0] FPEC_OFS_LATCH   = 16'h0008;
   // Control field positions
   localparam int          FPEC_BIT_PGM     = 0;
   localparam int          FPEC_BIT_ERASE   = 1;
   localparam int          FPEC_BIT_MASS    = 2;
   localparam int          FPEC_BIT_HV      = 3;
   localparam logic [7:0]  FPEC_CTRL_RESET  = 8'h00;
   localparam logic [7:0]  FPEC_PROT_NONE   = 8'hFF;
   localparam logic [7:0]  FPEC_ERASED      = 8'hFF;
   // Timing
   localparam int          FPEC_CLK_HZ      = 10_000_000;
   localparam int          FPEC_RCV_NS      = 1000;
   localparam int          FPEC_RCV_CYC     = (FPEC_RCV_NS * (FPEC_CLK_HZ / 1_000_000)
                                               + 999) / 1000;
   // Software step delays in clock cycles at 10 MHz
   localparam int          FPEC_SEL_HV_CYC  = 100;
   localparam int          FPEC_HOLD_CYC    = 10000;
   localparam int          FPEC_DESEL_CYC   = 50;
   typedef enum logic [1:0] {
      FPEC_SEQ_IDLE = 2'b00,
      FPEC_SEQ_SEL  = 2'b01,
      FPEC_SEQ_PROT = 2'b11,
      FPEC_SEQ_ARM  = 2'b10
   } fpec_seq_e;
   // Protected start address from the protect byte
   function automatic logic [15:0] fpec_prot_start(input logic [7:0] b);
      return {2'b11, b, 6'b00_0000};
   endfunction : fpec_prot_start
endpackage : fpec_pkg

// >>> logic/fpec_array_mem.sv
// Byte-wide flash array model with page/mass erase and byte program.
// Assumes one operation per cycle; read data is registered.
`timescale 1ns/100ps
module fpec_array_mem #(
   parameter int DEPTH = 8192,
   parameter int AW    = 13
) (
   // Clock
   input  wire logic          clk,
   // Access
   input  wire logic [AW-1:0] addr,
   input  wire logic          prog_en,
   input  wire logic [7:0]    prog_data,
   input  wire logic          page_erase,
   input  wire logic          mass_erase,
   output logic      [7:0]    rdata
);
   import fpec_pkg::*;
   // Fresh array reads erased; contents are not touched by reset
   logic [7:0] mem [DEPTH] = '{default: FPEC_ERASED};
   always_ff @(posedge clk) begin
      for (int i = 0; i < DEPTH; i++) begin
         if (mass_erase || (page_erase && (i / FPEC_PAGE_BYTES) == (addr / FPEC_PAGE_BYTES)))
            mem[i] <= FPEC_ERASED;
      end
      if (prog_en)
         mem[addr] <= mem[addr] & prog_data;
      rdata <= mem[addr];
   end
endmodule : fpec_array_mem

// >>> logic/fpec_recovery_timer.sv
// Counts read recovery after high voltage is removed.
// Assumes hv_on is a registered level.
`timescale 1ns/100ps
module fpec_recovery_timer #(
   parameter int CYC = 10
) (
   // Clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // Control
   input  wire logic hv_on,
   output logic      read_ok
);
   import fpec_pkg::*;
   logic [15:0] cnt_reg;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_reg <= 16'h0000;
      end else if (hv_on) begin
         cnt_reg <= 16'(CYC);
      end else if (cnt_reg != 16'h0000) begin
         cnt_reg <= cnt_reg - 16'h0001;
      end
   end
   assign read_ok = !hv_on && (cnt_reg == 16'h0000);
endmodule : fpec_recovery_timer

// >>> logic/fpec_ctrl.sv
// Flash page erase control: APB slave, sequence tracking, array access.
// Assumes APB byte addresses map flash bytes directly; software keeps timing.
//
// Register access over APB was left to the implementer.
`timescale 1ns/100ps
module fpec_ctrl #(
   parameter int AW = 13
) (
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [15:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Analog controls
   output logic             charge_pump_on,
   output logic             array_hv_on,
   output logic             array_read_ok
);
   import fpec_pkg::*;

   logic [7:0]    ctrl_reg;
   logic [7:0]    prot_reg;
   logic [AW-1:0] latch_reg;
   logic          latch_valid_reg;
   fpec_seq_e     seq_reg;
   logic          erase_done_reg;
   logic [7:0]    arr_rdata;
   logic          rd_wait_reg;
   logic          prot_loaded_reg;

   wire logic setup  = psel && !penable;
   wire logic access = psel && penable;
   wire logic ctl_hit   = (paddr[15:2] == FPEC_OFS_CTRL[15:2]);
   wire logic prot_hit  = (paddr[15:2] == FPEC_OFS_PROT[15:2]);
   wire logic stat_hit  = (paddr[15:2] == FPEC_OFS_STAT[15:2]);
   wire logic page_hit  = (paddr[15:2] == FPEC_OFS_PAGE[15:2]);

   function automatic logic in_flash(input logic [15:0] a);
      return ((a >= FPEC_USER_LO) && (a <= FPEC_USER_HI)) ||
             ((a >= FPEC_VECT_LO) && (a <= FPEC_VECT_HI)) ||
             (a == FPEC_PROT_ADDR);
   endfunction : in_flash

   wire logic flash_hit = in_flash(paddr) && !ctl_hit && !prot_hit;
   wire logic mapped    = ctl_hit || prot_hit || stat_hit || page_hit || flash_hit;
   // Array read needs one extra cycle for the registered memory output
   wire logic wr_ok = access && pwrite;
   wire logic rd_fire = access && !pwrite && pready;

   wire logic [7:0] wbyte = pwdata[7:0];
   wire logic program_select  = ctrl_reg[FPEC_BIT_PGM];
   wire logic ers  = ctrl_reg[FPEC_BIT_ERASE];
   wire logic mass = ctrl_reg[FPEC_BIT_MASS];
   wire logic hv   = ctrl_reg[FPEC_BIT_HV];
   wire logic [15:0] latch_addr = {3'b111, latch_reg};
   wire logic protected_any = (prot_reg != FPEC_PROT_NONE);
   // All ones in the protect byte protects nothing
   wire logic latch_prot = protected_any && (latch_addr >= fpec_prot_start(prot_reg));

   wire logic hv_allow = (program_select || ers) && (seq_reg == FPEC_SEQ_ARM)
                         && !latch_prot
                         && !(ers && mass && protected_any);

   // interlock on the next select pair
   logic new_pgm;
   logic new_ers;
   always_comb begin
      new_pgm = wbyte[FPEC_BIT_PGM];
      new_ers = wbyte[FPEC_BIT_ERASE];
      if (new_pgm && new_ers) begin
         new_pgm = program_select;
         new_ers = ers;
      end else if (new_pgm && ers) begin
         new_pgm = 1'b0;
      end else if (new_ers && program_select) begin
         new_ers = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg <= FPEC_CTRL_RESET;
      end else if (wr_ok && ctl_hit) begin
         ctrl_reg[FPEC_BIT_ERASE] <= new_ers;
         ctrl_reg[FPEC_BIT_PGM]   <= new_pgm;
         ctrl_reg[FPEC_BIT_MASS]  <= wbyte[FPEC_BIT_MASS];
         // a select must survive the same write
         ctrl_reg[FPEC_BIT_HV]    <= wbyte[FPEC_BIT_HV] &&
                                     (hv || (hv_allow && (new_pgm || new_ers)));
         ctrl_reg[7:4]            <= 4'h0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         seq_reg <= FPEC_SEQ_IDLE;
      end else if (!(program_select || ers) && !hv) begin
         seq_reg <= (wr_ok && ctl_hit && (new_pgm || new_ers)) ? FPEC_SEQ_SEL
                                                               : FPEC_SEQ_IDLE;
      end else begin
         unique case (seq_reg)
            FPEC_SEQ_IDLE: if (program_select || ers) seq_reg <= FPEC_SEQ_SEL;
            FPEC_SEQ_SEL:  if (rd_fire && prot_hit) seq_reg <= FPEC_SEQ_PROT;
            FPEC_SEQ_PROT: if (wr_ok && flash_hit) seq_reg <= FPEC_SEQ_ARM;
            FPEC_SEQ_ARM:  seq_reg <= FPEC_SEQ_ARM;
         endcase
      end
   end

   // page latch on first flash write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         latch_reg       <= '0;
         latch_valid_reg <= 1'b0;
      end else if (seq_reg == FPEC_SEQ_PROT && wr_ok && flash_hit) begin
         latch_reg       <= paddr[AW-1:0];
         latch_valid_reg <= 1'b1;
      end else if (seq_reg == FPEC_SEQ_IDLE) begin
         latch_valid_reg <= 1'b0;
      end
   end

   // Protect byte mirror; reloaded on each read of the protect address
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prot_reg        <= FPEC_PROT_NONE;
         prot_loaded_reg <= 1'b0;
      end else if (rd_fire && prot_hit) begin
         prot_reg        <= arr_rdata;
         prot_loaded_reg <= 1'b1;
      end
   end

   // Erase fires once per high-voltage period
   wire logic erase_now = hv && ers && !erase_done_reg && latch_valid_reg;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         erase_done_reg <= 1'b0;
      end else if (!hv) begin
         erase_done_reg <= 1'b0;
      end else if (erase_now) begin
         erase_done_reg <= 1'b1;
      end
   end

   // Program write: only with program select and high voltage
   wire logic prog_now = wr_ok && flash_hit && program_select && hv &&
                         (paddr >= FPEC_USER_LO) &&
                         (!protected_any || (paddr < fpec_prot_start(prot_reg)));

   // Reads take two cycles so registered array data is ready
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rd_wait_reg <= 1'b0;
      end else begin
         rd_wait_reg <= setup && !pwrite;
      end
   end
   assign pready  = access && (pwrite || !rd_wait_reg);
   assign pslverr = access && !mapped;

   // one 8 KB array holds every flash byte
   // page aligned erase; vector page shares aligned top page
   fpec_array_mem #(
      .DEPTH (1 << AW),
      .AW    (AW)
   ) u_mem (
      .clk        (pclk),
      .addr       (erase_now ? latch_reg : paddr[AW-1:0]),
      .prog_en    (prog_now),
      .prog_data  (wbyte),
      .page_erase (erase_now && !mass),
      .mass_erase (erase_now && mass),
      .rdata      (arr_rdata)
   );

   fpec_recovery_timer #(
      .CYC (FPEC_RCV_CYC)
   ) u_rcv (
      .pclk    (pclk),
      .presetn (presetn),
      .hv_on   (hv),
      .read_ok (array_read_ok)
   );

   // charge pump follows high voltage bit
   assign charge_pump_on = hv;
   assign array_hv_on    = hv;

   always_comb begin
      prdata = 32'h0000_0000;
      if (ctl_hit)
         prdata = {24'h00_0000, ctrl_reg};
      else if (stat_hit)
         prdata = {22'h0, prot_loaded_reg, latch_valid_reg, array_read_ok,
                   erase_done_reg, 2'(seq_reg), 4'h0};
      else if (page_hit)
         prdata = {16'h0000, latch_addr};
      else if (flash_hit || prot_hit)
         prdata = {24'h00_0000, arr_rdata};
   end
endmodule : fpec_ctrl

// >>> testbench/fpec_ctrl_properties.sv
// Port-level checker for the flash page erase control block.
// Assumes only the top module ports are visible; bound below.
`timescale 1ns/100ps
module fpec_ctrl_properties
   import fpec_pkg::*;
#(
   parameter int AW = 13
) (
   // Clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // APB slave
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [15:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // Analog controls
   input wire logic        charge_pump_on,
   input wire logic        array_hv_on,
   input wire logic        array_read_ok
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   chk_write_no_wait: assert property (psel && penable && pwrite |-> pready)
      else $error("write not answered in first access cycle");
   chk_read_one_wait: assert property (psel && $rose(penable) && !pwrite
      |-> !pready ##1 pready)
      else $error("read wait state wrong");
   chk_idle_quiet: assert property (!(psel && penable) |-> !pready && !pslverr)
      else $error("answer outside access phase");
   chk_err_no_data: assert property (pslverr && !pwrite |-> prdata == 32'h0000_0000)
      else $error("unmapped read returned data");
   chk_upper_zero: assert property (pready && !pwrite && paddr >= FPEC_USER_LO
      |-> prdata[31:8] == 24'h00_0000)
      else $error("upper read bits not zero");
   chk_page_upper: assert property (pready && !pwrite && paddr[15:2] == FPEC_OFS_PAGE[15:2]
      |-> prdata[31:16] == 16'h0000)
      else $error("page register upper bits not zero");
   chk_pump_pair: assert property (charge_pump_on == array_hv_on)
      else $error("pump and high voltage disagree");
   chk_hv_by_write: assert property ($changed(array_hv_on)
      |-> $past(psel && penable && pwrite && paddr == FPEC_CTRL_ADDR))
      else $error("high voltage changed without control write");
   chk_hv_needs_sel: assert property ($rose(array_hv_on) |-> $past(pwdata[0] | pwdata[1]))
      else $error("high voltage set with no select");
   chk_hv_blocks_read: assert property (array_hv_on |-> !array_read_ok)
      else $error("reads allowed under high voltage");
   chk_read_recovery: assert property ($fell(array_hv_on)
      |-> !array_read_ok [*8] ##[1:4] array_read_ok)
      else $error("read recovery time wrong");
   cov_hv_on: cover property ($rose(array_hv_on));
   cov_err: cover property (pslverr);
   cov_recover: cover property ($rose(array_read_ok));
endmodule : fpec_ctrl_properties

bind fpec_ctrl fpec_ctrl_properties #(.AW(AW)) i_props (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .charge_pump_on(charge_pump_on),
   .array_hv_on(array_hv_on), .array_read_ok(array_read_ok));

// >>> testbench/tb_fpec_ctrl.sv
// Self-checking bench for the flash page erase control block.
// Assumes the array model starts erased, protect byte all ones.
`timescale 1ns/100ps
module tb_fpec_ctrl;
   import fpec_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [15:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        cp, hv, rok, er;
   int          n_fail, comparisons, cyc;
   fpec_ctrl #(.AW(13)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .charge_pump_on(cp), .array_hv_on(hv),
      .array_read_ok(rok));
   always #50 pclk = ~pclk;
   task automatic final_report;
      $display("tests done: %0d comparisons, %0d mismatches", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : final_report
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         final_report();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk
   // Request held until pready is seen high at a rising edge; data taken there
   task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) chk(32'h0, 32'h1, "no pready");
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rdc(input logic [15:0] a, input logic [31:0] exp, input string what);
      apb(1'b0, a, 32'h0);
      chk(rd, exp, what);
   endtask : rdc
   task automatic pins(input logic [2:0] exp, input string what);
      @(negedge pclk);
      chk({29'h0, cp, hv, rok}, {29'h0, exp}, what);
   endtask : pins
   initial begin
      pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0;
      pwrite = 1'b0; paddr = 16'h0; pwdata = 32'h0;
      n_fail = 0; comparisons = 0; cyc = 0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      rdc(FPEC_CTRL_ADDR, 32'h0, "ctrl reset");
      pins(3'b001, "pins reset");
      $display("test reset done");
      apb(1'b1, FPEC_CTRL_ADDR, 32'h3);
      rdc(FPEC_CTRL_ADDR, 32'h0, "both selects");
      apb(1'b1, FPEC_CTRL_ADDR, 32'h1);
      rdc(FPEC_CTRL_ADDR, 32'h1, "program select");
      apb(1'b1, FPEC_CTRL_ADDR, 32'h3);
      rdc(FPEC_CTRL_ADDR, 32'h1, "erase over program");
      apb(1'b1, FPEC_CTRL_ADDR, 32'h0);
      apb(1'b1, FPEC_CTRL_ADDR, 32'h6);
      rdc(FPEC_CTRL_ADDR, 32'h6, "mass select");
      apb(1'b1, FPEC_CTRL_ADDR, 32'h0);
      apb(1'b1, FPEC_CTRL_ADDR, 32'h2);
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rdc(FPEC_CTRL_ADDR, 32'h0, "reset clears selects");
      $display("test interlock done");
      apb(1'b0, 16'h1000, 32'h0);
      chk({31'h0, er}, 32'h1, "unmapped error");
      chk(rd, 32'h0, "unmapped data");
      $display("test unmapped done");
      apb(1'b1, FPEC_CTRL_ADDR, 32'h1);
      apb(1'b0, FPEC_PROT_ADDR, 32'h0);
      apb(1'b1, 16'hE000, 32'h0);
      repeat (FPEC_SEL_HV_CYC) @(posedge pclk);
      apb(1'b1, FPEC_CTRL_ADDR, 32'h9);
      pins(3'b110, "program high voltage");
      apb(1'b1, 16'hE000, 32'h5A);
      apb(1'b1, 16'hE03F, 32'h0);
      apb(1'b1, FPEC_CTRL_ADDR, 32'h8);
      repeat (FPEC_DESEL_CYC) @(posedge pclk);
      apb(1'b1, FPEC_CTRL_ADDR, 32'h0);
      repeat (FPEC_RCV_CYC + 2) @(posedge pclk);
      rdc(16'hE000, 32'h5A, "programmed byte");
      rdc(16'hE03F, 32'h0, "programmed zero");
      $display("test program done");
      apb(1'b1, FPEC_CTRL_ADDR, 32'h2);
      apb(1'b1, FPEC_CTRL_ADDR, 32'hA);
      rdc(FPEC_CTRL_ADDR, 32'h2, "early hv refused");
      pins(3'b001, "hv stays off");
      apb(1'b0, FPEC_PROT_ADDR, 32'h0);
      apb(1'b1, 16'hE03F, 32'h5A);
      rdc(FPEC_OFS_PAGE, 32'h0000_E03F, "latched page");
      repeat (FPEC_SEL_HV_CYC) @(posedge pclk);
      apb(1'b1, FPEC_CTRL_ADDR, 32'hA);
      rdc(FPEC_CTRL_ADDR, 32'hA, "hv armed");
      pins(3'b110, "pump on, reads blocked");
      repeat (FPEC_HOLD_CYC) @(posedge pclk);
      apb(1'b1, FPEC_CTRL_ADDR, 32'h8);
      rdc(FPEC_CTRL_ADDR, 32'h8, "erase cleared");
      repeat (FPEC_DESEL_CYC) @(posedge pclk);
      apb(1'b1, FPEC_CTRL_ADDR, 32'h0);
      pins(3'b000, "recovery pending");
      repeat (12) @(posedge pclk);
      pins(3'b001, "recovery over");
      rdc(16'hE000, 32'hFF, "page start erased");
      rdc(16'hE03F, 32'hFF, "page end erased");
      $display("test page erase done");
      final_report();
   end
endmodule : tb_fpec_ctrl
